// [logic/hirs_image_reject_sync.sv]
// complex modulator with image-reject transform and multi-chip sync sequencer
`timescale 1ns/1ps
module hirs_image_reject_sync (
    // conversion clock and reset
    input wire logic clk,
    input wire logic rstn,
    // sync reference pin, received level used as link clock
    input wire logic syncRefClk,
    output logic syncRefOut,
    output logic syncRefOen,
    // datapath configuration
    input wire logic dualPathEnable,
    input wire logic channelSelect,
    input wire logic modulationSelectHi,
    input wire logic modulationSelectLo,
    input wire logic hilbertEnable,
    input wire logic sidebandSelect,
    input wire logic [1:0] interpSelect,
    // synchronisation configuration
    input wire logic syncEnable,
    input wire logic masterEnable,
    input wire logic masterKind,
    input wire logic [3:0] dataClockOffset,
    input wire logic [2:0] modulatorPhaseOffset,
    input wire logic phaseOffsetLoad,
    // sample stream from interpolation filters
    input wire logic signed [hirs_pkg::DATA_W-1:0] realIn,
    input wire logic signed [hirs_pkg::DATA_W-1:0] imagIn,
    output logic dataLatch,
    output logic signed [hirs_pkg::DATA_W-1:0] dacOut,
    // status
    output logic syncLocked,
    output logic [hirs_pkg::SEQ_W-1:0] seqState
);
    import hirs_pkg::*;

    // saturate a wide value to the path width
    function automatic logic signed [DATA_W-1:0] sat16(input logic signed [33:0] v);
        logic signed [33:0] hi;
        logic signed [33:0] lo;
        hi = 34'sh0_0000_7fff;
        lo = -34'sh0_0000_8000;
        if (v > hi) begin
            sat16 = 16'sh7fff;
        end else if (v < lo) begin
            sat16 = 16'sh8000;
        end else begin
            sat16 = v[DATA_W-1:0];
        end
    endfunction : sat16

    // round a Q14 product sum back to the path width
    function automatic logic signed [DATA_W-1:0] scaleLo(input logic signed [32:0] v);
        logic signed [33:0] r;
        r = (34'(v) + 34'sh0_0000_2000) >>> COEF_FRAC;
        scaleLo = sat16(r);
    endfunction : scaleLo

    // cosine of an angle in eighths of a cycle
    function automatic logic signed [COEF_W-1:0] cosOf(input logic [2:0] ang);
        logic signed [COEF_W-1:0] c;
        c = LO_ZERO;
        unique case (ang)
            3'h0: c = LO_ONE;
            3'h1: c = LO_RT2;
            3'h2: c = LO_ZERO;
            3'h3: c = LO_NEG_RT2;
            3'h4: c = LO_NEG_ONE;
            3'h5: c = LO_NEG_RT2;
            3'h6: c = LO_ZERO;
            3'h7: c = LO_RT2;
        endcase
        cosOf = c;
    endfunction : cosOf

    // ---------------- link domain ----------------
    // one toggle per reference rising edge; the clk side sees it as a level change
    logic refToggle;
    always_ff @(posedge syncRefClk or negedge rstn) begin
        if (!rstn) begin
            refToggle <= 1'b0;
        end else begin
            refToggle <= ~refToggle;
        end
    end

    // ---------------- crossing into clk ----------------
    logic refSync1;
    logic refSync2;
    logic refSync3;
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            refSync1 <= 1'b0;
            refSync2 <= 1'b0;
            refSync3 <= 1'b0;
        end else begin
            refSync1 <= refToggle;
            refSync2 <= refSync1;
            refSync3 <= refSync2;
        end
    end

    // roles: only a slave with sync enabled listens to the pin
    wire isSlave = syncEnable & ~masterEnable;
    wire isMaster = syncEnable & masterEnable;
    wire refEdge = refSync2 ^ refSync3;
    wire slaveAlign = isSlave & refEdge;

    // ---------------- sequencer ----------------
    // data-rate mask: low state bits that form one channel data period
    wire [SEQ_W-1:0] rateMask =
        (interpSelect == INTERP_X8) ? 4'h7 :
        (interpSelect == INTERP_X4) ? 4'h3 :
        (interpSelect == INTERP_X2) ? 4'h1 : 4'h0;
    wire [SEQ_W-1:0] rateHalf = rateMask ^ (rateMask >> 1);
    wire [SEQ_W-1:0] seqInc = seqState + 4'h1;
    // data-clock master only pins the data phase; modulator master pins all sixteen
    wire [SEQ_W-1:0] alignData = (seqInc & ~rateMask) | (SYNC_LAT & rateMask);
    wire [SEQ_W-1:0] next_seqState =
        !slaveAlign ? seqInc :
        (masterKind == REF_SYNC_REFERENCE_CLOCK_PIN) ? alignData : SYNC_LAT;
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            seqState <= SEQ_ZERO;
        end else begin
            seqState <= next_seqState;
        end
    end

    // ---------------- local data clock ----------------
    // offset is signed: positive advances the local clock, negative delays it
    wire [SEQ_W-1:0] next_adjState = next_seqState + dataClockOffset;
    wire [SEQ_W-1:0] next_adjPhase = next_adjState & rateMask;
    wire [SEQ_W-1:0] next_mstPhase = next_seqState & rateMask;
    wire next_dataLatch = (next_adjPhase == SEQ_ZERO);
    // at 1x the data clock equals the DAC clock and cannot be made from a flop: held high
    wire next_dataRef = (rateMask == SEQ_ZERO) | ((next_mstPhase & rateHalf) == SEQ_ZERO);
    wire next_modRef = ~next_seqState[SEQ_W-1];
    wire next_refOut = isMaster & ((masterKind == REF_SYNC_REFERENCE_CLOCK_PIN) ? next_dataRef : next_modRef);

    // pin driver and data strobe come straight from flops
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            syncRefOut <= 1'b0;
            syncRefOen <= 1'b1;
            dataLatch <= 1'b0;
        end else begin
            syncRefOut <= next_refOut;
            syncRefOen <= ~isMaster;
            dataLatch <= next_dataLatch;
        end
    end

    // ---------------- slave lock tracking ----------------
    hirs_lock_e lockState;
    hirs_lock_e next_lockState;
    always_comb begin
        next_lockState = lockState;
        if (!isSlave) begin
            next_lockState = HIRS_LK_OFF;
        end else begin
            unique case (lockState)
                HIRS_LK_OFF: next_lockState = HIRS_LK_WAIT;
                HIRS_LK_WAIT: next_lockState = refEdge ? HIRS_LK_ON : HIRS_LK_WAIT;
                HIRS_LK_ON: next_lockState = HIRS_LK_ON;
                default: next_lockState = HIRS_LK_OFF;
            endcase
        end
    end
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            lockState <= HIRS_LK_OFF;
            syncLocked <= 1'b0;
        end else begin
            lockState <= next_lockState;
            syncLocked <= (next_lockState == HIRS_LK_ON);
        end
    end

    // ---------------- modulator phase offset ----------------
    // a completed serial write is held and applied on entry to state zero, so a
    // group of slaves written together all switch on the same sequencer edge
    logic offsetPending;
    logic [2:0] offsetHeld;
    logic [2:0] offsetActive;
    wire applyNow = (next_seqState == SEQ_ZERO);
    wire [2:0] offsetNew = phaseOffsetLoad ? modulatorPhaseOffset : offsetHeld;
    // a write landing on the apply cycle goes straight in; pending is kept (set wins)
    wire next_offsetPending = phaseOffsetLoad | (offsetPending & ~applyNow);
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            offsetPending <= 1'b0;
            offsetHeld <= 3'h0;
            offsetActive <= 3'h0;
        end else begin
            offsetPending <= next_offsetPending;
            if (phaseOffsetLoad) begin
                offsetHeld <= modulatorPhaseOffset;
            end
            if (applyNow && (offsetPending || phaseOffsetLoad)) begin
                offsetActive <= offsetNew;
            end
        end
    end

    // ---------------- coefficient decode ----------------
    wire [1:0] modSel = {modulationSelectHi, modulationSelectLo};
    // coefficient index steps every 2, 4 or 8 states, in eighths of a cycle
    wire [2:0] baseAng =
        (modSel == MOD_EIGHTH) ? seqState[3:1] :
        (modSel == MOD_QUARTER) ? {seqState[3:2], 1'b0} :
        (modSel == MOD_HALF) ? {seqState[3], 2'b00} : 3'h0;
    wire modOn = (modSel != MOD_NONE);
    wire [2:0] mainAng = modOn ? baseAng + offsetActive : 3'h0;
    wire [2:0] xfrmAng = mainAng + ANG_QUARTER;
    // eighth-rate decode returns to zero on odd states
    wire oddZero = (modSel == MOD_EIGHTH) & seqState[0];
    wire signed [COEF_W-1:0] mainCos = oddZero ? LO_ZERO : cosOf(mainAng);
    wire signed [COEF_W-1:0] mainSin = (oddZero | !modOn) ? LO_ZERO : cosOf(mainAng - ANG_QUARTER);
    wire signed [COEF_W-1:0] xfrmCos = oddZero ? LO_ZERO : cosOf(xfrmAng);
    wire signed [COEF_W-1:0] xfrmSin = oddZero ? LO_ZERO : cosOf(xfrmAng - ANG_QUARTER);

    // ---------------- complex modulation ----------------
    wire signed [31:0] prodIc = realIn * mainCos;
    wire signed [31:0] prodQs = imagIn * mainSin;
    wire signed [31:0] prodIs = realIn * mainSin;
    wire signed [31:0] prodQc = imagIn * mainCos;
    wire signed [31:0] prodXIc = realIn * xfrmCos;
    wire signed [31:0] prodXQs = imagIn * xfrmSin;
    wire signed [31:0] prodXIs = realIn * xfrmSin;
    wire signed [31:0] prodXQc = imagIn * xfrmCos;
    wire signed [DATA_W-1:0] mainRe = scaleLo(33'(prodIc) - 33'(prodQs));
    wire signed [DATA_W-1:0] mainIm = scaleLo(33'(prodIs) + 33'(prodQc));
    wire signed [DATA_W-1:0] xfrmRe = scaleLo(33'(prodXIc) - 33'(prodXQs));
    wire signed [DATA_W-1:0] xfrmIm = scaleLo(33'(prodXIs) + 33'(prodXQc));
    // single channel: chosen input times the real sinusoid
    wire signed [31:0] singleProd = (channelSelect ? imagIn : realIn) * mainCos;
    wire signed [DATA_W-1:0] singleOut = scaleLo(33'(singleProd));
    wire signed [DATA_W-1:0] next_mainY =
        !dualPathEnable ? singleOut : (channelSelect ? mainIm : mainRe);
    wire signed [DATA_W-1:0] next_xfrmY = channelSelect ? xfrmIm : xfrmRe;

    logic signed [DATA_W-1:0] mainY;
    logic signed [DATA_W-1:0] xfrmY;
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            mainY <= 16'sh0000;
            xfrmY <= 16'sh0000;
        end else begin
            mainY <= next_mainY;
            xfrmY <= next_xfrmY;
        end
    end

    // ---------------- main path delay ----------------
    logic signed [DATA_W-1:0] mainDel [0:HB_DELAY-1];
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            for (int i = 0; i < HB_DELAY; i++) begin
                mainDel[i] <= 16'sh0000;
            end
        end else begin
            mainDel[0] <= mainY;
            for (int i = 1; i < HB_DELAY; i++) begin
                mainDel[i] <= mainDel[i-1];
            end
        end
    end

    // ---------------- transform FIR ----------------
    // tap 0 is xfrmY itself, so the centre tap lines up with the last main delay stage
    logic signed [DATA_W-1:0] xfrmLine [0:HB_TAPS-2];
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            for (int i = 0; i < HB_TAPS - 1; i++) begin
                xfrmLine[i] <= 16'sh0000;
            end
        end else begin
            xfrmLine[0] <= xfrmY;
            for (int i = 1; i < HB_TAPS - 1; i++) begin
                xfrmLine[i] <= xfrmLine[i-1];
            end
        end
    end

    // odd taps are zero, so only the even-numbered taps cost a multiplier
    logic signed [31:0] hbSum;
    always_comb begin
        hbSum = 32'(xfrmY) * 32'(HB_COEF[0]);
        for (int k = 2; k < HB_TAPS; k += 2) begin
            hbSum = hbSum + 32'(xfrmLine[k-1]) * 32'(HB_COEF[k]);
        end
    end
    // divide by 512 with rounding back to the path width
    wire signed [33:0] hbRound = (34'(hbSum) + 34'sh0_0000_0100) >>> HB_SHIFT;
    wire signed [DATA_W-1:0] hbOut = sat16(hbRound);

    // ---------------- output summation ----------------
    wire hbActive = dualPathEnable & hilbertEnable;
    wire signed [33:0] mainWide = 34'(mainDel[HB_DELAY-1]);
    wire signed [33:0] hbWide = 34'(hbOut);
    // sideband 0 adds the transform, 1 subtracts it
    wire signed [33:0] sumWide = sidebandSelect ? mainWide - hbWide : mainWide + hbWide;
    wire signed [DATA_W-1:0] next_dacOut = hbActive ? sat16(sumWide) : mainY;
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            dacOut <= 16'sh0000;
        end else begin
            dacOut <= next_dacOut;
        end
    end
endmodule : hirs_image_reject_sync

// [logic/hirs_pkg.sv]
// constants and types for the image-reject modulator and sync sequencer
// Function
// - dual mode: transform off at 0, on at 1
// - transform is nineteen-tap FIR at DAC rate
// - antisymmetric integer taps, odd taps zero
// - transform output summed into main path
// - main path delayed nine DAC cycles
// - transform-path LO leads by quarter cycle
// - sideband 0 rejects upper, 1 rejects lower
// - master drives sync pin, slaves receive it
// - sixteen-state sequencer steps every DAC clock
// - modulator master: 16-cycle square, rising at zero
// - slave aligns state zero to master edge
// - data-clock master: reference at channel rate
// - new phase offset applied at next state zero
// - modulator-master slaves lock phase automatically
// - slave latches data with sequencer-derived clock
// - data clock offset: advance eight, delay seven
// - coefficients decoded from sequencer state every clock
// - index steps every 2, 4, 8 states
// - phase offset rotates coefficients against state zero
// - modulation select: none, half, quarter, eighth
// - dual mode complex; channel picks real or imaginary
package hirs_pkg;
    localparam int DATA_W = 16;
    localparam int COEF_W = 16;
    localparam int COEF_FRAC = 14;
    localparam logic signed [COEF_W-1:0] LO_ONE = 16'sh4000;
    localparam logic signed [COEF_W-1:0] LO_RT2 = 16'sh2d41;
    localparam logic signed [COEF_W-1:0] LO_ZERO = 16'sh0000;
    localparam logic signed [COEF_W-1:0] LO_NEG_RT2 = 16'shd2bf;
    localparam logic signed [COEF_W-1:0] LO_NEG_ONE = 16'shc000;
    localparam int HB_TAPS = 19;
    localparam int HB_DELAY = 9;
    localparam int HB_COEF_W = 10;
    localparam int HB_SHIFT = 9;
    localparam logic signed [HB_COEF_W-1:0] HB_COEF [0:HB_TAPS-1] = '{
        10'h3fa, 10'h000, 10'h3ef, 10'h000, 10'h3d8, 10'h000, 10'h3a5, 10'h000,
        10'h2c2, 10'h000, 10'h13e, 10'h000, 10'h05b, 10'h000, 10'h028, 10'h000,
        10'h011, 10'h000, 10'h006};
    localparam int SEQ_W = 4;
    localparam logic [SEQ_W-1:0] SEQ_ZERO = 4'h0;
    localparam logic [SEQ_W-1:0] SYNC_LAT = 4'h3;
    localparam logic [2:0] ANG_QUARTER = 3'h2;
    localparam logic [1:0] MOD_NONE = 2'h0;
    localparam logic [1:0] MOD_HALF = 2'h1;
    localparam logic [1:0] MOD_QUARTER = 2'h2;
    localparam logic [1:0] MOD_EIGHTH = 2'h3;
    localparam logic [1:0] INTERP_X1 = 2'h0;
    localparam logic [1:0] INTERP_X2 = 2'h1;
    localparam logic [1:0] INTERP_X4 = 2'h2;
    localparam logic [1:0] INTERP_X8 = 2'h3;
    localparam logic REF_MODULATOR = 1'b0;
    localparam logic REF_SYNC_REFERENCE_CLOCK_PIN = 1'b1;
    typedef enum logic [1:0] {
        HIRS_LK_OFF = 2'b00,
        HIRS_LK_WAIT = 2'b01,
        HIRS_LK_ON = 2'b11
    } hirs_lock_e;
endpackage : hirs_pkg

// [tb/hirs_image_reject_sync_properties.sv]
// port checks for the modulator, sync pin and sequencer
`timescale 1ns/1ps
module hirs_image_reject_sync_properties (
    // clock and reset
    input wire logic clk,
    input wire logic rstn,
    // configuration
    input wire logic syncEnable,
    input wire logic masterEnable,
    input wire logic masterKind,
    input wire logic dualPathEnable,
    input wire logic channelSelect,
    input wire logic modulationSelectHi,
    input wire logic modulationSelectLo,
    input wire logic [1:0] interpSelect,
    input wire logic [3:0] dataClockOffset,
    input wire logic signed [hirs_pkg::DATA_W-1:0] realIn,
    // outputs watched
    input wire logic syncRefOut,
    input wire logic syncRefOen,
    input wire logic dataLatch,
    input wire logic signed [hirs_pkg::DATA_W-1:0] dacOut,
    input wire logic syncLocked,
    input wire logic [hirs_pkg::SEQ_W-1:0] seqState
);
    import hirs_pkg::*;
    // data period mask; 1x has none, so the data-clock reference sits high
    wire [3:0] dMask = (4'h1 << interpSelect) - 4'h1;
    wire refHigh = masterKind ? (dMask == 4'h0 || (seqState & dMask) < ((dMask + 4'h1) >> 1))
        : (seqState < 4'h8);
    wire slaveRole = syncEnable && !masterEnable;
    wire plainPath = !dualPathEnable && !channelSelect && !modulationSelectHi
        && !modulationSelectLo;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);
    // outputs are registered, so causes are taken one edge back
    AST_SEQ_STEP: assert property (
        $past(rstn) && !$past(slaveRole) |-> seqState == $past(seqState) + 4'h1)
        else $error("sequencer did not step by one");
    AST_REF_SHAPE: assert property (
        $past(rstn) && $past(syncEnable && masterEnable) && $stable(interpSelect)
        && $stable(masterKind) |-> syncRefOut == refHigh)
        else $error("master reference level wrong for state");
    AST_PIN_ENABLE: assert property (
        $past(rstn) |-> syncRefOen == !$past(syncEnable && masterEnable))
        else $error("sync pin enable wrong for role");
    AST_PIN_IDLE: assert property (
        $past(rstn) && !$past(syncEnable && masterEnable) |-> !syncRefOut)
        else $error("sync pin driven high while not master");
    AST_LATCH_PHASE: assert property (
        $past(rstn) && $stable(interpSelect) && $stable(dataClockOffset)
        |-> dataLatch == (((seqState + dataClockOffset) & dMask) == 4'h0))
        else $error("data latch off its phase");
    AST_LOCK_STATE: assert property (
        $rose(syncLocked) |-> (masterKind ? (seqState & dMask) == (SYNC_LAT & dMask)
        : seqState == SYNC_LAT))
        else $error("slave alignment loaded wrong state");
    AST_NO_LOCK_MASTER: assert property (
        $past(rstn) && !$past(slaveRole) |-> !$rose(syncLocked))
        else $error("lock rose outside slave role");
    AST_LOCK_HOLD: assert property (
        $past(rstn) && $past(syncLocked && slaveRole) |-> syncLocked)
        else $error("slave lost lock");
    AST_PLAIN_PATH: assert property (
        $past(rstn) && $past(rstn, 2) && $past(plainPath) && $past(plainPath, 2)
        |-> dacOut == $past(realIn, 2))
        else $error("plain path output not input two cycles back");
    CV_LOCK: cover property ($rose(syncLocked));
    CV_MASTER_ZERO: cover property (!syncRefOen && syncRefOut && seqState == 4'h0);
    CV_LATCH8: cover property (dataLatch && interpSelect == INTERP_X8);
endmodule : hirs_image_reject_sync_properties

// [tb/hirs_sync_partner.sv]
// far converter acting as sync master on the shared reference pin
`timescale 1ns/1ps
module hirs_sync_partner (
    // high while the far device is the group master
    input wire logic run,
    // pin level; low when released since the pin is pulled down
    output logic refOut
);
    // own reference clock, phase unrelated to the local clock
    initial begin
        refOut = 1'b0;
        #3.7;
        forever begin
            #62.5;
            refOut = run ? !refOut : 1'b0;
        end
    end
endmodule : hirs_sync_partner

// [tb/testbench.sv]
// self-checking bench: sequencer, sync pin, modulator and transform
`timescale 1ns/1ps
module testbench;
    import hirs_pkg::*;
    // design inputs, all set at time zero
    logic clk = 1'b0, rstn = 1'b0, dualPathEnable = 1'b0, channelSelect = 1'b0;
    logic modulationSelectHi = 1'b0, modulationSelectLo = 1'b0, hilbertEnable = 1'b0;
    logic sidebandSelect = 1'b0, syncEnable = 1'b0, masterEnable = 1'b0, masterKind = 1'b0;
    logic phaseOffsetLoad = 1'b0;
    logic [1:0] interpSelect = 2'h0;
    logic [3:0] dataClockOffset = 4'h0;
    logic [2:0] modulatorPhaseOffset = 3'h0;
    logic signed [DATA_W-1:0] realIn = 16'sh0000, imagIn = 16'sh0000;
    // outputs and the shared pin
    logic syncRefOut, syncRefOen, dataLatch, syncLocked, partnerRef;
    logic signed [DATA_W-1:0] dacOut;
    logic [SEQ_W-1:0] seqState;
    wire syncRefClk = !syncRefOen ? syncRefOut : partnerRef;
    int n_mismatch = 0, check_count = 0, seed = 18, offAct = 0, offPend = -1;
    int offTab [4] = '{6, 4, 2, 3};
    int hTab [19] = '{-6, 0, -17, 0, -40, 0, -91, 0, -318, 0, 318, 0, 91, 0, 40, 0, 17, 0, 6};

    hirs_image_reject_sync u_hirs_image_reject_sync (.clk, .rstn, .syncRefClk, .syncRefOut,
        .syncRefOen, .dualPathEnable, .channelSelect, .modulationSelectHi, .modulationSelectLo,
        .hilbertEnable, .sidebandSelect, .interpSelect, .syncEnable, .masterEnable, .masterKind,
        .dataClockOffset, .modulatorPhaseOffset, .phaseOffsetLoad, .realIn, .imagIn,
        .dataLatch, .dacOut, .syncLocked, .seqState);
    hirs_sync_partner u_hirs_sync_partner (.run(syncEnable && !masterEnable), .refOut(partnerRef));

    always #5 clk = !clk;

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("FAIL at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic test_done();
        if (n_mismatch == 0 && check_count > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : test_done

    // cosine in eighths of a turn
    function automatic logic signed [15:0] cosAt(input int ang);
        case (ang & 7)
            0: return LO_ONE;
            1, 7: return LO_RT2;
            3, 5: return LO_NEG_RT2;
            4: return LO_NEG_ONE;
            default: return LO_ZERO;
        endcase
    endfunction : cosAt

    // coefficient for a mode and state; eighth rate blanks odd states
    function automatic logic signed [15:0] loAt(input logic [1:0] m, input logic [3:0] s,
        input int off);
        case (m)
            MOD_HALF: return cosAt(4 * s[3] + off);
            MOD_QUARTER: return cosAt(2 * s[3:2] + off);
            MOD_EIGHTH: return s[0] ? LO_ZERO : cosAt(s[3:1] + off);
            default: return LO_ONE;
        endcase
    endfunction : loAt

    // product back in Q14 with saturation; exact for the values used
    function automatic logic [15:0] modOut(input logic signed [15:0] a,
        input logic signed [15:0] c);
        logic signed [31:0] p;
        p = (a * c) >>> 14;
        return (p > 32767) ? 16'h7fff : (p < -32768) ? 16'h8000 : p[15:0];
    endfunction : modOut

    task automatic doReset();
        rstn = 1'b0;
        repeat (16) @(negedge clk);
        check(seqState, 16'h0000);
        check(dacOut, 16'h0000);
        check(syncRefOen, 16'h0001);
        check(syncLocked, 16'h0000);
        rstn = 1'b1;
    endtask : doReset

    // bounded wait for the slave to see the far reference
    task automatic waitLock();
        for (int i = 0; i < 60 && syncLocked !== 1'b1; i++)
            @(negedge clk);
        check(syncLocked, 16'h0001);
        if (syncLocked !== 1'b1)
            test_done();
    endtask : waitLock

    // master run per interpolation, offsets include the +8 and -7 limits
    task automatic runMaster(input logic kind);
        syncEnable = 1'b1;
        masterEnable = 1'b1;
        masterKind = kind;
        for (int k = 0; k < 4; k++) begin
            interpSelect = 2'(k);
            dataClockOffset = (k == 3) ? 4'h8 : (k == 2) ? 4'h9 : 4'($random(seed));
            repeat (20) @(negedge clk);
            for (int i = 0; i < 16 && seqState !== 4'h0; i++)
                @(negedge clk);
            // a sequencer that never reaches state zero ends the run here
            if (seqState !== 4'h0) begin
                n_mismatch++;
                test_done();
            end
            check(syncRefOut, 16'h0001);
            check(syncRefOen, 16'h0000);
        end
    endtask : runMaster

    // single channel modulation; the other channel carries the inverse
    task automatic runMod(input logic [1:0] m, input int off);
        logic signed [15:0] a;
        logic [15:0] e1 = 16'h0000, e2 = 16'h0000;
        bit v1 = 1'b0, v2 = 1'b0;
        {modulationSelectHi, modulationSelectLo} = m;
        channelSelect = m[0];
        for (int i = 0; i < 48; i++) begin
            @(negedge clk);
            if (v2)
                check(dacOut, e2);
            if (seqState == 4'h0 && offPend >= 0) begin
                offAct = offPend;
                offPend = -1;
            end
            phaseOffsetLoad = (i == 9);
            if (i == 9) begin
                modulatorPhaseOffset = 3'(off);
                offPend = off;
            end
            a = (m == MOD_EIGHTH) ? 16'sh4000 : (i == 20) ? 16'sh8000 : 16'($random(seed));
            realIn = m[0] ? ~a : a;
            imagIn = m[0] ? a : ~a;
            e2 = e1;
            v2 = v1;
            e1 = modOut(a, loAt(m, seqState, offAct));
            // angle 7 of the eighth-rate decode is left unchecked
            v1 = !(m == MOD_EIGHTH && 3'(seqState[3:1] + offAct) == 3'h7);
        end
    endtask : runMod

    // impulses: 0x100 into the main path, 0x200 through the transform; the chosen
    // result flips which input feeds which path and the sign of the transform term
    task automatic runFir(input logic hb, input logic sb, input logic ch);
        int e;
        dualPathEnable = 1'b1;
        hilbertEnable = hb;
        sidebandSelect = sb;
        {modulationSelectHi, modulationSelectLo} = MOD_NONE;
        channelSelect = ch;
        // flush what the modulation runs left in the delay lines
        realIn = 16'sh0000;
        imagIn = 16'sh0000;
        repeat (24) @(negedge clk);
        realIn = ch ? 16'sh0200 : 16'sh0100;
        imagIn = ch ? 16'sh0100 : 16'sh0200;
        for (int j = 1; j <= 22; j++) begin
            @(negedge clk);
            realIn = 16'sh0000;
            imagIn = 16'sh0000;
            e = hb ? (j == 11 ? 256 : 0)
                + ((j >= 2 && j <= 20) ? ((sb ^ ch) ? 1 : -1) * hTab[j-2] : 0)
                : (j == 2 ? 256 : 0);
            check(dacOut, 16'(e));
        end
    endtask : runFir

    // hang guard
    initial begin
        #900us;
        n_mismatch++;
        test_done();
    end

    initial begin
        doReset();
        runMaster(REF_MODULATOR);
        runMaster(REF_SYNC_REFERENCE_CLOCK_PIN);
        syncEnable = 1'b0;
        interpSelect = INTERP_X1;
        for (int m = 0; m < 4; m++)
            runMod(2'(m), offTab[m]);
        runFir(1'b0, 1'b0, 1'b0);
        runFir(1'b1, 1'b0, 1'b0);
        runFir(1'b1, 1'b1, 1'b0);
        runFir(1'b1, 1'b0, 1'b1);
        dualPathEnable = 1'b0;
        syncEnable = 1'b1;
        masterEnable = 1'b0;
        masterKind = REF_MODULATOR;
        waitLock();
        doReset();
        masterKind = REF_SYNC_REFERENCE_CLOCK_PIN;
        interpSelect = INTERP_X8;
        waitLock();
        repeat (30) @(negedge clk);
        test_done();
    end
endmodule : testbench

bind hirs_image_reject_sync hirs_image_reject_sync_properties u_hirs_image_reject_sync_properties (
    .clk, .rstn, .syncEnable, .masterEnable, .masterKind, .dualPathEnable, .channelSelect,
    .modulationSelectHi, .modulationSelectLo, .interpSelect, .dataClockOffset, .realIn,
    .syncRefOut, .syncRefOen, .dataLatch, .dacOut, .syncLocked, .seqState);
